// File: verilog/ddrb_port.sv
// Operation
// - Single-clock mode runs output registers from the input clock, same timing.
// - Read right after write to same address returns the newest written data.
// - Both selects from idle start read first, then alternate.
// - Both selects after a read started last cycle: write wins.
// - Both selects after a write started last cycle: read wins.
// - Port selects sampled only on the rising input clock edge.
// - Deselecting one port leaves the other alone; pending bursts always finish.
// - Output driver impedance recalibrated every 1024 clock cycles.
// - Two free-running echo strobes follow the input clock in both clock modes, in opposite phase.
// - PLL on: lock arrives 20 us after stable clock, no reset needed.
// - Input clock slowed or stopped 30 ns resets the PLL, which relocks.
// - PLL bypass pin low disables PLL, one cycle read latency.
// - Write words A,A+1 arrive at t+1, A+2,A+3 at t+2.
// - PLL on: read word A at t+1, A+1 and A+2 in t+2, A+3 at t+3.
// - Low lane select writes its lane; high select leaves lane unchanged.
// - All selects high on a beat stores nothing; selects change per beat.
// - Second read or write on consecutive edges is ignored.
// - Select that started an operation last cycle is don't-care now.
// - Burst order is A, A+1, A+2, A+3 for reads and writes.
// - Power-up with both ports deselected and read outputs tristated.
// - Read latency 1.5 cycles with PLL on, 1 cycle with bypass.
// - After deselect and pending reads, outputs tristate after next rising edge.
module ddrb_port #(
  parameter int ADDR_W = ddrb_pkg::ADDR_W,
  parameter int DATA_W = ddrb_pkg::DATA_W,
  parameter int LANES = ddrb_pkg::LANES,
  parameter int LANE_W = ddrb_pkg::LANE_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [DATA_W-1:0] write_data_rise,
  input wire logic [DATA_W-1:0] write_data_fall,
  input wire logic [LANES-1:0] byte_write_select_n_rise,
  input wire logic [LANES-1:0] byte_write_select_n_fall,
  input wire logic out_clock_pos_level,
  input wire logic out_clock_neg_level,
  input wire logic pll_bypass_n,
  input wire logic input_clock_stalled,
  input wire logic impedance_pin_high,
  output logic [DATA_W-1:0] read_data_rise,
  output logic [DATA_W-1:0] read_data_fall,
  output logic read_oe_rise,
  output logic read_oe_fall,
  output logic echo_strobe_pos,
  output logic echo_strobe_neg,
  output logic single_clock_mode,
  output logic pll_locked,
  output logic [ddrb_pkg::DRIVE_W-1:0] drive_code,
  output logic impedance_update
);
  import ddrb_pkg::*;

  localparam int BW = BURST_LEN * DATA_W;
  localparam int MW = BURST_LEN * LANES;

  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [LANES-1:0] lane_n
  );
    logic [DATA_W-1:0] res;
    res = old_word;
    for (int l = 0; l < LANES; l++) begin
      if (!lane_n[l]) begin
        res[l*LANE_W +: LANE_W] = new_word[l*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction

  ddrb_last_e last_q, last_d;
  logic rd_s1_q, rd_s2_q, rd_s3_q;
  logic wr_s1_q, wr_s2_q;
  logic [ADDR_W-1:0] rd_addr_q, wr_addr_q;
  logic [BW-1:0] rd_word_q;
  logic [DATA_W-1:0] rise_q, fall_q, rise_d, fall_d;
  logic oe_rise_q, oe_fall_q, oe_rise_d, oe_fall_d;
  logic echo_q;
  logic strap_taken_q, single_q;
  logic [LOCK_CNT_W-1:0] lock_cnt_q;
  logic locked_q;
  logic [STALL_CNT_W-1:0] stall_cnt_q;
  logic [ZQ_CNT_W-1:0] zq_cnt_q;
  logic [DRIVE_W-1:0] drive_q;
  logic zq_pulse_q;

  // Arbitration of the shared address bus
  wire rd_req = !read_port_select_n && !rd_s1_q;
  wire wr_req = !write_port_select_n && !wr_s1_q;
  logic start_rd, start_wr;
  always_comb begin
    start_rd = rd_req && !wr_req;
    start_wr = wr_req && !rd_req;
    if (rd_req && wr_req) begin
      unique case (last_q)
        LAST_NONE: start_rd = 1'b1;
        LAST_READ: start_wr = 1'b1;
        LAST_WRITE: start_rd = 1'b1;
        default: start_rd = 1'b1;
      endcase
    end
    last_d = start_rd ? LAST_READ : (start_wr ? LAST_WRITE : LAST_NONE);
  end

  // Write column enables: A,A+1 at t+1, A+2,A+3 at t+2
  wire [BURST_LEN-1:0] col_we = {wr_s2_q, wr_s2_q, wr_s1_q, wr_s1_q};
  wire [BW-1:0] col_wdata = {write_data_fall, write_data_rise, write_data_fall, write_data_rise};
  wire [MW-1:0] col_mask = {byte_write_select_n_fall, byte_write_select_n_rise,
                            byte_write_select_n_fall, byte_write_select_n_rise};
  wire [BW-1:0] arr_rdata;

  ddrb_array #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .LANES(LANES),
    .LANE_W(LANE_W),
    .BURST_LEN(BURST_LEN)
  ) u_array (
    .clock(clock),
    .wr_en(col_we),
    .wr_addr(wr_addr_q),
    .wr_data(col_wdata),
    .wr_lane_n(col_mask),
    .rd_addr(rd_addr_q),
    .rd_data(arr_rdata)
  );

  // Forwarding of write beats landing in the same edge as the read fetch
  wire same_addr = (wr_addr_q == rd_addr_q);
  wire [BW-1:0] merged;
  genvar c;
  generate
    for (c = 0; c < BURST_LEN; c++) begin : g_fwd
      assign merged[c*DATA_W +: DATA_W] = (col_we[c] && same_addr) ?
        lane_merge(arr_rdata[c*DATA_W +: DATA_W], col_wdata[c*DATA_W +: DATA_W],
                   col_mask[c*LANES +: LANES]) :
        arr_rdata[c*DATA_W +: DATA_W];
    end
  endgenerate

  wire pll_on = pll_bypass_n;
  wire [DATA_W-1:0] m0 = merged[0 +: DATA_W];
  wire [DATA_W-1:0] m1 = merged[DATA_W +: DATA_W];
  wire [DATA_W-1:0] w1 = rd_word_q[DATA_W +: DATA_W];
  wire [DATA_W-1:0] w2 = rd_word_q[2*DATA_W +: DATA_W];
  wire [DATA_W-1:0] w3 = rd_word_q[3*DATA_W +: DATA_W];

  // Output beat selection per latency mode
  always_comb begin
    rise_d = '0;
    oe_rise_d = 1'b0;
    if (rd_s1_q && !pll_on) begin
      rise_d = m0;
      oe_rise_d = 1'b1;
    end else if (rd_s2_q) begin
      rise_d = pll_on ? w1 : w2;
      oe_rise_d = 1'b1;
    end else if (rd_s3_q && pll_on) begin
      rise_d = w3;
      oe_rise_d = 1'b1;
    end
    fall_d = '0;
    oe_fall_d = 1'b0;
    if (rd_s1_q) begin
      fall_d = pll_on ? m0 : m1;
      oe_fall_d = 1'b1;
    end else if (rd_s2_q) begin
      fall_d = pll_on ? w2 : w3;
      oe_fall_d = 1'b1;
    end
  end

  // Transaction pipeline
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_q <= LAST_NONE;
      rd_s1_q <= 1'b0;
      rd_s2_q <= 1'b0;
      rd_s3_q <= 1'b0;
      wr_s1_q <= 1'b0;
      wr_s2_q <= 1'b0;
    end else begin
      last_q <= last_d;
      rd_s1_q <= start_rd;
      rd_s2_q <= rd_s1_q;
      rd_s3_q <= rd_s2_q;
      wr_s1_q <= start_wr;
      wr_s2_q <= wr_s1_q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_addr_q <= '0;
      wr_addr_q <= '0;
      rd_word_q <= '0;
    end else begin
      if (start_rd) begin
        rd_addr_q <= address;
      end
      if (start_wr) begin
        wr_addr_q <= address;
      end
      if (rd_s1_q) begin
        rd_word_q <= merged;
      end
    end
  end

  // Output registers, tristate when no beat is due
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rise_q <= '0;
      fall_q <= '0;
      oe_rise_q <= 1'b0;
      oe_fall_q <= 1'b0;
    end else begin
      rise_q <= rise_d;
      fall_q <= fall_d;
      oe_rise_q <= oe_rise_d;
      oe_fall_q <= oe_fall_d;
    end
  end

  // Echo strobe and clock-mode strap
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      echo_q <= 1'b0;
      strap_taken_q <= 1'b0;
      single_q <= 1'b0;
    end else begin
      echo_q <= !echo_q;
      strap_taken_q <= 1'b1;
      if (!strap_taken_q) begin
        single_q <= out_clock_pos_level && out_clock_neg_level;
      end
    end
  end

  // PLL lock tracking
  wire stall_long = (stall_cnt_q >= STALL_CNT_W'(PLL_STALL_CYC));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stall_cnt_q <= '0;
      lock_cnt_q <= '0;
      locked_q <= 1'b0;
    end else begin
      if (!input_clock_stalled) begin
        stall_cnt_q <= '0;
      end else if (!stall_long) begin
        stall_cnt_q <= stall_cnt_q + 1'b1;
      end
      if (!pll_on || stall_long) begin
        lock_cnt_q <= '0;
        locked_q <= 1'b0;
      end else if (input_clock_stalled) begin
        lock_cnt_q <= '0;
      end else if (lock_cnt_q == LOCK_CNT_W'(PLL_LOCK_CYC - 1)) begin
        locked_q <= 1'b1;
      end else begin
        lock_cnt_q <= lock_cnt_q + 1'b1;
      end
    end
  end

  // Periodic driver impedance update
  wire zq_due = (zq_cnt_q == ZQ_CNT_W'(ZQ_PERIOD_CYC - 1));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      zq_cnt_q <= '0;
      drive_q <= DRIVE_RESET;
      zq_pulse_q <= 1'b0;
    end else begin
      zq_cnt_q <= zq_due ? '0 : zq_cnt_q + 1'b1;
      zq_pulse_q <= zq_due;
      if (zq_due) begin
        if (impedance_pin_high && drive_q != DRIVE_MAX) begin
          drive_q <= drive_q + 1'b1;
        end else if (!impedance_pin_high && drive_q != DRIVE_MIN) begin
          drive_q <= drive_q - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      echo_strobe_neg <= 1'b1;
    end else begin
      echo_strobe_neg <= echo_q;
    end
  end

  assign read_data_rise = rise_q;
  assign read_data_fall = fall_q;
  assign read_oe_rise = oe_rise_q;
  assign read_oe_fall = oe_fall_q;
  assign echo_strobe_pos = echo_q;
  assign single_clock_mode = single_q;
  assign pll_locked = locked_q;
  assign drive_code = drive_q;
  assign impedance_update = zq_pulse_q;
endmodule

// File: verilog/ddrb_pkg.sv
package ddrb_pkg;
  localparam int ADDR_W = 18;
  localparam int LANES = 2;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int BURST_LEN = 4;
  localparam int BEAT_W = 2;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PLL_LOCK_US = 20;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_STALL_NS = 30;
  localparam int PLL_STALL_RAW = (PLL_STALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_STALL_CYC = (PLL_STALL_RAW < 1) ? 1 : PLL_STALL_RAW;
  localparam int ZQ_PERIOD_CYC = 1024;
  localparam int ZQ_CNT_W = 10;
  localparam int LOCK_CNT_W = 8;
  localparam int STALL_CNT_W = 4;
  localparam int DRIVE_W = 6;
  localparam logic [DRIVE_W-1:0] DRIVE_RESET = 6'h20;
  localparam logic [DRIVE_W-1:0] DRIVE_MAX = 6'h3f;
  localparam logic [DRIVE_W-1:0] DRIVE_MIN = 6'h00;

  typedef enum logic [1:0] {
    LAST_NONE = 2'b00,
    LAST_READ = 2'b01,
    LAST_WRITE = 2'b10
  } ddrb_last_e;
endpackage

// File: verilog/ddrb_array.sv
module ddrb_array #(
  parameter int ADDR_W = ddrb_pkg::ADDR_W,
  parameter int DATA_W = ddrb_pkg::DATA_W,
  parameter int LANES = ddrb_pkg::LANES,
  parameter int LANE_W = ddrb_pkg::LANE_W,
  parameter int BURST_LEN = ddrb_pkg::BURST_LEN
) (
  input wire logic clock,
  input wire logic [BURST_LEN-1:0] wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [BURST_LEN*DATA_W-1:0] wr_data,
  input wire logic [BURST_LEN*LANES-1:0] wr_lane_n,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [BURST_LEN*DATA_W-1:0] rd_data
);
  import ddrb_pkg::*;

  genvar c;
  generate
    for (c = 0; c < BURST_LEN; c++) begin : g_col
      logic [DATA_W-1:0] mem [2**ADDR_W];
      always_ff @(posedge clock) begin
        for (int l = 0; l < LANES; l++) begin
          if (wr_en[c] && !wr_lane_n[c*LANES+l]) begin
            mem[wr_addr][l*LANE_W +: LANE_W] <= wr_data[c*DATA_W + l*LANE_W +: LANE_W];
          end
        end
      end
      assign rd_data[c*DATA_W +: DATA_W] = mem[rd_addr];
    end
  endgenerate
endmodule

// File: tb/ddrb_port_assertions.sv
module ddrb_port_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic pll_bypass_n,
  input wire logic input_clock_stalled,
  input wire logic read_oe_rise,
  input wire logic read_oe_fall,
  input wire logic echo_strobe_pos,
  input wire logic echo_strobe_neg,
  input wire logic pll_locked,
  input wire logic impedance_update
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] gap_q;
  logic [8:0] good_q;
  logic seen_q;
  logic stall_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gap_q <= 11'h000;
      good_q <= 9'h000;
      seen_q <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      gap_q <= impedance_update ? 11'h000 : gap_q + 11'(gap_q != 11'h7ff);
      stall_q <= input_clock_stalled;
      good_q <= (input_clock_stalled || stall_q || !pll_bypass_n) ? 9'h000 : good_q + 9'(good_q != 9'h1ff);
      seen_q <= seen_q || impedance_update;
    end
  end
  // Lone read start from an idle read port
  sequence rd_go;
    $past(read_port_select_n) && !read_port_select_n && write_port_select_n;
  endsequence
  echo_toggle_a: assert property (1 |=> (echo_strobe_pos ^ echo_strobe_neg) && $changed(echo_strobe_pos))
    else $error("echo strobes not toggling");
  rd_lat_on_a: assert property (rd_go ##0 pll_bypass_n |-> ##2 read_oe_fall ##1 (read_oe_rise && read_oe_fall) ##1 read_oe_rise)
    else $error("read beats misplaced with pll on");
  rd_lat_byp_a: assert property (rd_go ##0 !pll_bypass_n |-> ##2 (read_oe_rise && read_oe_fall) [*2])
    else $error("read beats misplaced in bypass");
  rd_release_a: assert property (read_port_select_n [*4] |=> !read_oe_rise && !read_oe_fall)
    else $error("read outputs not released");
  zq_period_a: assert property (seen_q |-> (gap_q < 11'h3ff && !impedance_update) || (gap_q == 11'h3ff && impedance_update))
    else $error("impedance update period wrong");
  lock_early_a: assert property (good_q < 9'h0be && !stall_q |-> !pll_locked)
    else $error("pll locked too early");
  lock_late_a: assert property (good_q > 9'h0d2 |-> pll_locked)
    else $error("pll lock missing");
  stall_unlock_a: assert property (input_clock_stalled || !pll_bypass_n |-> ##[1:2] !pll_locked)
    else $error("pll lock kept after stall");
  cover property (rd_go ##0 pll_bypass_n);
  cover property (rd_go ##0 !pll_bypass_n);
  cover property (!read_port_select_n && !write_port_select_n);
endmodule

// File: tb/ddrb_ctl.sv
module ddrb_ctl #(parameter int AW = 5) (
  input wire logic clock,
  input wire logic [ddrb_pkg::DATA_W-1:0] read_data_rise,
  input wire logic [ddrb_pkg::DATA_W-1:0] read_data_fall,
  input wire logic read_oe_rise,
  input wire logic read_oe_fall,
  output logic [AW-1:0] address,
  output logic read_port_select_n,
  output logic write_port_select_n,
  output logic [2*ddrb_pkg::DATA_W-1:0] wdata,
  output logic [3:0] wsel_n
);
  timeunit 1ns;
  timeprecision 1ns;
  import ddrb_pkg::*;
  logic [DATA_W-1:0] got[$];
  initial begin
    address = '0;
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    wdata = '0;
    wsel_n = 4'h0;
  end
  // One command edge per call
  task automatic step(input logic rn, input logic wn, input logic [AW-1:0] a, input logic [2*DATA_W-1:0] d,
                      input logic [3:0] m);
    @(negedge clock);
    read_port_select_n = rn;
    write_port_select_n = wn;
    address = a;
    wdata = d;
    wsel_n = m;
  endtask
  // Idle edges carry flipping junk with lanes enabled
  task automatic idle(input int n);
    repeat (n) step(1'b1, 1'b1, ~address, ~wdata, 4'h0);
  endtask
  always @(posedge clock) begin
    #1;
    if (read_oe_rise) got.push_back(read_data_rise);
    if (read_oe_fall) got.push_back(read_data_fall);
  end
endmodule

// File: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ddrb_pkg::*;
  localparam int AW = 5;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic pll_bypass_n = 1'b1;
  logic input_clock_stalled = 1'b0;
  logic strap = 1'b0;
  logic impedance_pin_high = 1'b1;
  logic echo_strobe_pos, echo_strobe_neg;
  logic [DRIVE_W-1:0] drive_code;
  logic [AW-1:0] address;
  logic read_port_select_n, write_port_select_n, read_oe_rise, read_oe_fall;
  logic single_clock_mode, pll_locked, impedance_update;
  logic [2*DATA_W-1:0] wdata;
  logic [3:0] wsel_n;
  logic [DATA_W-1:0] read_data_rise, read_data_fall;
  logic [DATA_W-1:0] mem[32][4];
  int error_cnt = 0;
  int checks_done = 0;
  ddrb_port #(.ADDR_W(AW)) u_ddrb_port (.clock, .rst, .address, .read_port_select_n, .write_port_select_n,
    .write_data_rise(wdata[2*DATA_W-1:DATA_W]), .write_data_fall(wdata[DATA_W-1:0]),
    .byte_write_select_n_rise(wsel_n[3:2]), .byte_write_select_n_fall(wsel_n[1:0]),
    .out_clock_pos_level(strap), .out_clock_neg_level(strap), .pll_bypass_n, .input_clock_stalled,
    .impedance_pin_high, .read_data_rise, .read_data_fall, .read_oe_rise, .read_oe_fall,
    .echo_strobe_pos, .echo_strobe_neg, .single_clock_mode, .pll_locked, .drive_code, .impedance_update);
  ddrb_ctl #(.AW(AW)) u_ddrb_ctl (.clock, .read_data_rise, .read_data_fall, .read_oe_rise, .read_oe_fall,
    .address, .read_port_select_n, .write_port_select_n, .wdata, .wsel_n);
  initial forever #50 clock = ~clock;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [DATA_W-1:0] wd(input int s);
    return DATA_W'(s * 32'h0000_1c3b);
  endfunction
  function automatic logic [DATA_W-1:0] mg(input logic [DATA_W-1:0] o, input logic [DATA_W-1:0] n,
                                           input logic [1:0] m);
    return {m[1] ? o[DATA_W-1:LANE_W] : n[DATA_W-1:LANE_W], m[0] ? o[LANE_W-1:0] : n[LANE_W-1:0]};
  endfunction
  // Beat pair into columns c, c+1; a low rn holds both selects low
  task automatic beats(input logic rn, input logic [AW-1:0] a, input int c, input int s, input logic [3:0] m);
    u_ddrb_ctl.step(rn, rn, a, {wd(s), wd(s + 1)}, m);
    mem[a][c] = mg(mem[a][c], wd(s), m[3:2]);
    mem[a][c + 1] = mg(mem[a][c + 1], wd(s + 1), m[1:0]);
  endtask
  task automatic wr(input logic [AW-1:0] a, input int s, input logic [7:0] m);
    u_ddrb_ctl.step(1'b1, 1'b0, a, ~wdata, 4'h0);
    beats(1'b1, a, 0, s, m[7:4]);
    beats(1'b1, a, 2, s + 2, m[3:0]);
  endtask
  task automatic expect_rd(input logic [AW-1:0] a);
    for (int k = 0; k < 4; k++) chk("read word", u_ddrb_ctl.got.pop_front(), mem[a][k]);
  endtask
  task automatic rd(input logic [AW-1:0] a);
    u_ddrb_ctl.step(1'b0, 1'b1, a, ~wdata, 4'h0);
    u_ddrb_ctl.idle(5);
    chk("read count", u_ddrb_ctl.got.size(), 4);
    expect_rd(a);
  endtask
  task automatic t_write_read();
    wr(5'h03, 10, 8'h00);
    rd(5'h03);
    wr(5'h03, 20, 8'hb4);
    rd(5'h03);
  endtask
  task automatic t_both();
    u_ddrb_ctl.step(1'b0, 1'b0, 5'h03, ~wdata, 4'h0);
    u_ddrb_ctl.step(1'b0, 1'b0, 5'h07, ~wdata, 4'h0);
    beats(1'b0, 5'h07, 0, 40, 4'h0);
    beats(1'b1, 5'h07, 2, 42, 4'h0);
    u_ddrb_ctl.idle(5);
    chk("both count", u_ddrb_ctl.got.size(), 8);
    expect_rd(5'h03);
    expect_rd(5'h07);
  endtask
  task automatic t_refuse();
    u_ddrb_ctl.step(1'b0, 1'b1, 5'h03, ~wdata, 4'h0);
    u_ddrb_ctl.step(1'b0, 1'b1, 5'h07, ~wdata, 4'h0);
    u_ddrb_ctl.idle(5);
    chk("refuse count", u_ddrb_ctl.got.size(), 4);
    expect_rd(5'h03);
  endtask
  task automatic t_bypass();
    pll_bypass_n = 1'b0;
    u_ddrb_ctl.idle(3);
    chk("lock in bypass", pll_locked, 0);
    rd(5'h07);
    pll_bypass_n = 1'b1;
  endtask
  task automatic t_pll();
    u_ddrb_ctl.idle(215);
    chk("lock", pll_locked, 1);
    input_clock_stalled = 1'b1;
    u_ddrb_ctl.idle(1);
    input_clock_stalled = 1'b0;
    u_ddrb_ctl.idle(2);
    chk("lock after stall", pll_locked, 0);
  endtask
  task automatic t_zq();
    int n;
    logic [DRIVE_W-1:0] d0;
    n = 0;
    d0 = drive_code;
    for (int k = 0; k < 2048; k++) begin
      impedance_pin_high = (k < 1024);
      u_ddrb_ctl.idle(1);
      n += int'(impedance_update === 1'b1);
      if (k == 1023) chk("drive up", drive_code, d0 + 1'b1);
    end
    chk("update count", n, 2);
    chk("drive down", drive_code, d0);
    impedance_pin_high = 1'b1;
  endtask
  task automatic rst_dut(input logic s);
    logic e;
    rst = 1'b1;
    strap = s;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    u_ddrb_ctl.idle(2);
    chk("single clock", single_clock_mode, s);
    chk("outputs off", {read_oe_rise, read_oe_fall}, 0);
    chk("drive reset", drive_code, DRIVE_RESET);
    chk("echo pair", echo_strobe_pos ^ echo_strobe_neg, 1);
    e = echo_strobe_pos;
    u_ddrb_ctl.idle(1);
    chk("echo toggle", echo_strobe_pos, !e);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #(4000 * 100);
    error_cnt++;
    end_of_test();
  end
  initial begin
    rst_dut(1'b0);
    t_write_read();
    t_both();
    t_refuse();
    t_bypass();
    t_pll();
    t_zq();
    rst_dut(1'b1);
    end_of_test();
  end
endmodule
bind ddrb_port ddrb_port_chk u_ddrb_port_chk (.clock, .rst, .read_port_select_n, .write_port_select_n,
  .pll_bypass_n, .input_clock_stalled, .read_oe_rise, .read_oe_fall, .echo_strobe_pos, .echo_strobe_neg,
  .pll_locked, .impedance_update);
